// >>> design/uwir_pkg.sv
// uwir_pkg: register map, field layout and carrier types of the usb wrapper irq/aggregation block
package uwir_pkg;
	// byte addresses of the word registers
	localparam logic [7:0] UWIR_OFS_MASKED_EP = 8'h00; // masked_irq_status_endpoints
	localparam logic [7:0] UWIR_OFS_MASKED_CORE = 8'h04; // masked_irq_status_core
	localparam logic [7:0] UWIR_OFS_EOI = 8'h08; // end_of_interrupt
	localparam logic [7:0] UWIR_OFS_VEC_LOW = 8'h0C; // irq_vector_low
	localparam logic [7:0] UWIR_OFS_VEC_HIGH = 8'h10; // irq_vector_high
	localparam logic [7:0] UWIR_OFS_EP1_LOW = 8'h14; // ep1_aggregate_size_low
	localparam logic [7:0] UWIR_OFS_EP1_HIGH = 8'h18; // ep1_aggregate_size_high
	localparam logic [7:0] UWIR_OFS_EP2_LOW = 8'h1C; // ep2_aggregate_size_low
	localparam logic [7:0] UWIR_OFS_EP2_HIGH = 8'h20; // ep2_aggregate_size_high
	localparam logic [7:0] UWIR_OFS_AGG_CTRL = 8'h24; // receive_aggregation_mode enables
	localparam logic [7:0] UWIR_OFS_RAW_EP = 8'h28; // raw endpoint sources, unmasked
	localparam logic [7:0] UWIR_OFS_RAW_CORE = 8'h2C; // raw core sources, unmasked
	// field layout: implemented bits of each 16-bit register
	localparam logic [15:0] UWIR_EP_FIELDS = 16'h1F1F; // rx 12-8, tx 4-0
	localparam logic [15:0] UWIR_CORE_FIELDS = 16'h01FF; // usb 8-0
	localparam logic [15:0] UWIR_EOI_FIELDS = 16'h00FF; // irq_ack_vector 7-0
	localparam logic [15:0] UWIR_TOP_FIELDS = 16'h0001; // count_top bit 0
	localparam logic [15:0] UWIR_CTRL_FIELDS = 16'h0003; // one enable per endpoint
	localparam int UWIR_HALF_W = 16; // register data width
	localparam int UWIR_SIZE_W = 17; // aggregation byte count width
	localparam int UWIR_NUM_EP = 2; // endpoints with aggregation here
	// reset values
	localparam logic [7:0] UWIR_EOI_RESET = 8'h00;
	localparam logic [16:0] UWIR_SIZE_RESET = 17'h0_0000;
	localparam logic [31:0] UWIR_RDATA_ZERO = 32'h0000_0000;
	// one received usb packet from the receive path
	typedef struct packed {
		logic valid; // one-cycle pulse per packet
		logic short_pkt; // packet shorter than max packet size
		logic [10:0] bytes; // bytes in this packet
	} uwir_rx_s;
	// one completed dma packet towards the dma path
	typedef struct packed {
		logic close; // one-cycle pulse: dma packet complete
		logic [16:0] length; // bytes merged into it
	} uwir_dma_s;
	// interrupt source inputs from the usb core
	typedef struct packed {
		logic [15:0] src_ep; // raw endpoint sources
		logic [15:0] src_core; // raw core sources
		logic [15:0] mask_ep; // endpoint masks, same bit positions
		logic [15:0] mask_core; // core masks, same bit positions
	} uwir_irq_s;
endpackage

// >>> design/uwir_regs.sv
// uwir_regs: masked irq view, end-of-interrupt, vector read-back and rx aggregation sizes
// Functional notes
// - masked status bit is source and mask
// - endpoint view: rx 12-8, tx 4-0
// - core view: bits 8-0, rest zero
// - writing zero to ack field acknowledges
// - vector input read as two halves
// - ep1 merges packets until size reached
// - short packet closes merged packet early
// - 17-bit size from low and top
// - ep2 has identical size and merge
// - same bit positions in all views
// - raw sources stay visible, never masked
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module uwir_regs
	import uwir_pkg::*;
#(
	parameter int RX_BYTES_W = 11 // width of per-packet byte count
)
(
	input wire logic i_sys_clk, // 25 mhz system clock
	input wire logic i_rstn, // asynchronous reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb access phase
	input wire logic i_pwrite, // apb direction, high for write
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic o_pready, // apb ready, from flop
	output logic [31:0] o_prdata, // apb read data, from flop
	output logic o_pslverr, // apb error on unmapped address
	input wire uwir_pkg::uwir_irq_s i_irq, // core sources and masks
	input wire logic [31:0] i_irq_vector, // incoming interrupt vector
	input wire uwir_pkg::uwir_rx_s i_rx_ep1, // ep1 received packets
	input wire uwir_pkg::uwir_rx_s i_rx_ep2, // ep2 received packets
	output uwir_pkg::uwir_dma_s o_dma_ep1, // ep1 dma packet completions
	output uwir_pkg::uwir_dma_s o_dma_ep2, // ep2 dma packet completions
	output logic o_irq, // interrupt request, level
	output logic o_eoi_pulse // acknowledge seen, one cycle
);
	import uwir_pkg::*;

	// the per-packet count must fit the 17-bit accumulator
	if (RX_BYTES_W < 1 || RX_BYTES_W > 11)
	begin : g_bad_width
		$error("RX_BYTES_W must lie between 1 and 11");
	end

	// whole state of the block
	typedef struct packed {
		logic pready; // answer phase of the bus
		logic [31:0] prdata; // read data held for the answer
		logic pslverr; // error answer
		logic [7:0] ack_vec; // irq_ack_vector field
		logic eoi_pulse; // acknowledge strobe
		logic irq; // interrupt request
		logic [1:0][16:0] size; // programmed aggregation counts
		logic [1:0] agg_en; // receive_aggregation_mode per endpoint
		logic [1:0][16:0] acc; // bytes merged so far
		logic [1:0] close; // dma packet completion strobes
		logic [1:0][16:0] len; // length of the completed dma packet
	} uwir_state_s;

	uwir_state_s st_q; // registered state
	uwir_state_s st_d; // next state
	logic [15:0] masked_ep; // endpoint masked view
	logic [15:0] masked_core; // core masked view
	logic bus_done; // access phase completes at this edge
	logic wr_en; // write takes effect at this edge
	uwir_rx_s [1:0] rx; // both receive inputs as one array

	// masking keeps each bit at its own position; reserved bits drop out
	function automatic logic [15:0] mask_view(input logic [15:0] src, input logic [15:0] msk,
		input logic [15:0] fields);
		mask_view = src & msk & fields;
	endfunction

	// place a 16-bit value in the low half of a bus word
	function automatic logic [31:0] half_word(input logic [15:0] v);
		half_word = {16'h0000, v};
	endfunction

	// decode a read; unmapped gives an error flag
	function automatic logic [32:0] read_mux(input logic [7:0] a, input uwir_state_s s,
		input logic [15:0] m_ep, input logic [15:0] m_core, input logic [31:0] vec,
		input uwir_irq_s irq);
		logic [15:0] v;
		logic bad;
		v = 16'h0000;
		bad = 1'b0;
		case (a)
			UWIR_OFS_MASKED_EP: v = m_ep;
			UWIR_OFS_MASKED_CORE: v = m_core;
			UWIR_OFS_EOI: v = {8'h00, s.ack_vec};
			UWIR_OFS_VEC_LOW: v = vec[15:0];
			UWIR_OFS_VEC_HIGH: v = vec[31:16];
			UWIR_OFS_EP1_LOW: v = s.size[0][15:0];
			UWIR_OFS_EP1_HIGH: v = {15'h0000, s.size[0][16]};
			UWIR_OFS_EP2_LOW: v = s.size[1][15:0];
			UWIR_OFS_EP2_HIGH: v = {15'h0000, s.size[1][16]};
			UWIR_OFS_AGG_CTRL: v = {14'h0000, s.agg_en};
			UWIR_OFS_RAW_EP: v = irq.src_ep & UWIR_EP_FIELDS;
			UWIR_OFS_RAW_CORE: v = irq.src_core & UWIR_CORE_FIELDS;
			default: bad = 1'b1; // unmapped: zero data, error
		endcase
		read_mux = {bad, half_word(v)};
	endfunction

	// one merge step: returns close, new accumulator, completed length
	function automatic logic [34:0] merge_step(input logic [16:0] acc, input logic [16:0] size,
		input logic en, input uwir_rx_s r);
		logic [17:0] sum;
		logic done;
		sum = {1'b0, acc} + {7'h00, r.bytes};
		done = 1'b0;
		if (r.valid)
		begin
			// without aggregation each usb packet is its own dma packet
			done = !en || r.short_pkt || (sum >= {1'b0, size});
		end
		if (!r.valid)
			merge_step = {1'b0, acc, 17'h0_0000};
		else if (done)
			merge_step = {1'b1, UWIR_SIZE_RESET, sum[16:0]};
		else
			merge_step = {1'b0, sum[16:0], 17'h0_0000};
	endfunction

	assign masked_ep = mask_view(i_irq.src_ep, i_irq.mask_ep, UWIR_EP_FIELDS);
	assign masked_core = mask_view(i_irq.src_core, i_irq.mask_core, UWIR_CORE_FIELDS);
	assign bus_done = i_psel && i_penable && st_q.pready;
	assign wr_en = bus_done && i_pwrite;
	assign rx[0] = i_rx_ep1;
	assign rx[1] = i_rx_ep2;

	// next state: bus slave, acknowledge, irq, size registers, merge engines
	always_comb
	begin
		logic [32:0] rd;
		logic [34:0] step;
		rd = 33'h0_0000_0000;
		step = 35'h0_0000_0000;
		st_d = st_q;
		st_d.eoi_pulse = 1'b0; // strobes last one cycle
		st_d.close = 2'b00;
		// one wait state: ready rises in the second access cycle
		st_d.pready = i_psel && i_penable && !st_q.pready;
		if (i_psel && i_penable && !st_q.pready)
		begin
			rd = read_mux(i_paddr, st_q, masked_ep, masked_core, i_irq_vector, i_irq);
			st_d.prdata = i_pwrite ? UWIR_RDATA_ZERO : rd[31:0];
			st_d.pslverr = rd[32];
		end
		else if (!st_q.pready)
		begin
			st_d.prdata = UWIR_RDATA_ZERO;
			st_d.pslverr = 1'b0;
		end
		// writes land only at the edge that completes the transfer
		if (wr_en)
		begin
			case (i_paddr)
				UWIR_OFS_EOI:
				begin
					st_d.ack_vec = i_pwdata[7:0];
					st_d.eoi_pulse = (i_pwdata[7:0] == UWIR_EOI_RESET);
				end
				UWIR_OFS_EP1_LOW: st_d.size[0][15:0] = i_pwdata[15:0];
				UWIR_OFS_EP1_HIGH: st_d.size[0][16] = i_pwdata[0];
				UWIR_OFS_EP2_LOW: st_d.size[1][15:0] = i_pwdata[15:0];
				UWIR_OFS_EP2_HIGH: st_d.size[1][16] = i_pwdata[0];
				UWIR_OFS_AGG_CTRL: st_d.agg_en = i_pwdata[1:0];
				default: ; // read-only or unmapped: write ignored
			endcase
		end
		// the request drops for one cycle after an ack so the cpu sees a new edge
		st_d.irq = ((|masked_ep) || (|masked_core)) && !st_d.eoi_pulse;
		// both endpoints run the same engine; a size write mid-packet applies at once
		for (int e = 0; e < UWIR_NUM_EP; e++)
		begin
			step = merge_step(st_q.acc[e], st_q.size[e], st_q.agg_en[e], rx[e]);
			st_d.close[e] = step[34];
			st_d.acc[e] = step[33:17];
			if (step[34])
				st_d.len[e] = step[16:0];
		end
	end

	// state register; constants only under reset
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_q <= '0; // all fields reset to zero, ack field included
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state flops
	assign o_pready = st_q.pready;
	assign o_prdata = st_q.prdata;
	assign o_pslverr = st_q.pslverr;
	assign o_irq = st_q.irq;
	assign o_eoi_pulse = st_q.eoi_pulse;
	assign o_dma_ep1 = '{close: st_q.close[0], length: st_q.len[0]};
	assign o_dma_ep2 = '{close: st_q.close[1], length: st_q.len[1]};

	// read of the endpoint masked view returns source and mask
	a_masked_ep_read: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == UWIR_OFS_MASKED_EP)
		|=> o_prdata == {16'h0000, $past(i_irq.src_ep & i_irq.mask_ep) & UWIR_EP_FIELDS})
		else $error("endpoint masked view wrong");

	// reserved bits of the core view read zero
	a_core_reserved: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_pready && $past(i_paddr) == UWIR_OFS_MASKED_CORE) |-> o_prdata[31:9] == '0)
		else $error("core view reserved bits set");

	// ack write of zero gives one strobe and drops the request
	a_eoi_strobe: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr_en && i_paddr == UWIR_OFS_EOI && i_pwdata[7:0] == UWIR_EOI_RESET)
		|=> o_eoi_pulse && !o_irq ##1 !o_eoi_pulse)
		else $error("acknowledge strobe wrong");

	// vector high half matches the input
	a_vector_high: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == UWIR_OFS_VEC_HIGH)
		|=> o_prdata == {16'h0000, $past(i_irq_vector[31:16])})
		else $error("vector high half wrong");

	// short packet always closes the ep1 merged packet next cycle
	a_short_close: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_rx_ep1.valid && i_rx_ep1.short_pkt) |=> o_dma_ep1.close && st_q.acc[0] == '0)
		else $error("short packet did not close");

	// reaching the programmed count closes with that length
	a_size_close: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_rx_ep1.valid && st_q.agg_en[0] && (st_q.acc[0] + i_rx_ep1.bytes) == st_q.size[0])
		|=> o_dma_ep1.close && o_dma_ep1.length == $past(st_q.size[0]))
		else $error("merge did not close at size");

	// ep2 keeps merging below its count
	a_ep2_merge: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_rx_ep2.valid && !i_rx_ep2.short_pkt && st_q.agg_en[1]
		&& ({1'b0, st_q.acc[1]} + i_rx_ep2.bytes) < {1'b0, st_q.size[1]})
		|=> !o_dma_ep2.close && st_q.acc[1] == $past(st_q.acc[1] + i_rx_ep2.bytes))
		else $error("ep2 closed early");

	// top size register keeps only bit 0
	a_size_top: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == UWIR_OFS_EP1_HIGH)
		|=> o_prdata == {31'h0000_0000, st_q.size[0][16]})
		else $error("size top reads wrong");

	// request follows any masked source one cycle later, unless a zero ack lands
	// built from the raw inputs so a broken mask path cannot hide behind itself
	a_irq_level: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(((|(i_irq.src_ep & i_irq.mask_ep & UWIR_EP_FIELDS))
		|| (|(i_irq.src_core & i_irq.mask_core & UWIR_CORE_FIELDS)))
		&& !(wr_en && i_paddr == UWIR_OFS_EOI && i_pwdata[7:0] == UWIR_EOI_RESET))
		|=> o_irq)
		else $error("irq missing while masked bit set");

	// raw view ignores the masks
	a_raw_visible: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == UWIR_OFS_RAW_EP)
		|=> o_prdata[15:0] == ($past(i_irq.src_ep) & UWIR_EP_FIELDS))
		else $error("raw view masked");
endmodule

// >>> testbench/uwir_rx_src.sv
// uwir_rx_src: receive path model that hands usb packets to both endpoints
`timescale 1ns/100ps
module uwir_rx_src
	import uwir_pkg::*;
(
	input wire logic i_sys_clk, // system clock
	output uwir_pkg::uwir_rx_s o_rx_ep1, // ep1 packets
	output uwir_pkg::uwir_rx_s o_rx_ep2 // ep2 packets
);
	// quiet lines at time zero
	initial
	begin
		o_rx_ep1 = '0;
		o_rx_ep2 = '0;
	end
	// one packet per call; back-to-back calls give valid in consecutive cycles
	// the other endpoint goes quiet, else its last packet would be taken again
	task automatic send(input int ep, input logic [10:0] n, input logic sh);
		uwir_rx_s p;
		p = '{valid: 1'b1, short_pkt: sh, bytes: n};
		@(posedge i_sys_clk);
		if (ep == 1)
		begin
			o_rx_ep1 <= p;
			o_rx_ep2.valid <= 1'b0;
		end
		else
		begin
			o_rx_ep2 <= p;
			o_rx_ep1.valid <= 1'b0;
		end
	endtask
	// between packets the fields are not held: inverted so stale values cannot pass
	task automatic idle();
		@(posedge i_sys_clk);
		o_rx_ep1 <= '{valid: 1'b0, short_pkt: ~o_rx_ep1.short_pkt, bytes: ~o_rx_ep1.bytes};
		o_rx_ep2 <= '{valid: 1'b0, short_pkt: ~o_rx_ep2.short_pkt, bytes: ~o_rx_ep2.bytes};
	endtask
endmodule

// >>> testbench/uwir_regs_test.sv
// uwir_regs_test: apb-driven self-checking bench for the irq and aggregation registers
`timescale 1ns/100ps
module uwir_regs_test;
	import uwir_pkg::*;
	logic sys_clk = 1'b0; // 25 mhz system clock
	logic rstn = 1'b0; // reset, active low
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
	logic [7:0] paddr = 8'h00; // apb address
	logic [31:0] pwdata = 32'h0000_0000, vec = 32'h0000_0000; // write data, vector input
	logic [31:0] prdata, rv; // read data and its captured copy
	logic pready, pslverr, irq_req, eoi_pulse, re; // block outputs, captured error
	uwir_irq_s irq_in = '0; // core sources and masks
	uwir_rx_s rx1, rx2; // packets from the receive model
	uwir_dma_s dma1, dma2; // dma completions
	int n_mismatch = 0, samples_checked = 0, n_close1 = 0, n_close2 = 0, n_eoi = 0;
	logic [16:0] len1, len2; // last completed lengths

	uwir_regs i_dut (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_irq(irq_in), .i_irq_vector(vec),
		.i_rx_ep1(rx1), .i_rx_ep2(rx2), .o_dma_ep1(dma1), .o_dma_ep2(dma2), .o_irq(irq_req),
		.o_eoi_pulse(eoi_pulse));
	uwir_rx_src i_rx (.i_sys_clk(sys_clk), .o_rx_ep1(rx1), .o_rx_ep2(rx2));

	// free-running clock, 40 ns period
	initial
	begin
		forever #20 sys_clk = ~sys_clk;
	end
	// pulses counted mid-cycle, where the flops have settled
	always @(negedge sys_clk)
	begin
		if (dma1.close === 1'b1)
		begin
			n_close1++;
			len1 = dma1.length;
		end
		if (dma2.close === 1'b1)
		begin
			n_close2++;
			len2 = dma2.length;
		end
		if (eoi_pulse === 1'b1)
			n_eoi++;
	end
	// one comparison, reported at once on mismatch
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// apb transfer; an idle edge first keeps back-to-back calls from double driving
	// the request holds until the rising edge at which ready is seen high;
	// data and error are taken at that edge, then the request is released
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1)
			n_mismatch++;
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rv);
	endtask
	// prints the verdict and ends the run
	task automatic complete_run();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		rd("eoi reset", UWIR_OFS_EOI, 32'h0000_0000);
		rd("ep1 high reset", UWIR_OFS_EP1_HIGH, 32'h0000_0000);
		irq_in <= '{src_ep: 16'hEF3C, src_core: 16'hFE5A, mask_ep: 16'hFF15, mask_core: 16'h03C3};
		vec <= 32'hA5C3_3C5A;
		rd("masked ep", UWIR_OFS_MASKED_EP, 32'h0000_0F14);
		rd("masked core", UWIR_OFS_MASKED_CORE, 32'h0000_0042);
		rd("raw ep", UWIR_OFS_RAW_EP, 32'h0000_0F1C);
		rd("raw core", UWIR_OFS_RAW_CORE, 32'h0000_005A);
		rd("vector low", UWIR_OFS_VEC_LOW, 32'h0000_3C5A);
		rd("vector high", UWIR_OFS_VEC_HIGH, 32'h0000_A5C3);
		chk("irq raised", 32'h0000_0001, {31'h0, irq_req});
		// zero write acknowledges; request must come back while masked bits remain
		apb(1'b1, UWIR_OFS_EOI, 32'h0000_0000);
		repeat (3) @(negedge sys_clk);
		chk("ack pulses", 32'h0000_0001, n_eoi);
		chk("irq after ack", 32'h0000_0001, {31'h0, irq_req});
		apb(1'b1, UWIR_OFS_EOI, 32'hFFFF_FF5A);
		rd("eoi field", UWIR_OFS_EOI, 32'h0000_005A);
		chk("no ack on nonzero", 32'h0000_0001, n_eoi);
		irq_in.mask_ep <= 16'h0000;
		irq_in.mask_core <= 16'h0000;
		repeat (3) @(negedge sys_clk);
		chk("irq masked off", 32'h0000_0000, {31'h0, irq_req});
		rd("raw ep unmasked", UWIR_OFS_RAW_EP, 32'h0000_0F1C);
		// aggregation sizes: multiples of 64 and within 65536
		apb(1'b1, UWIR_OFS_EP1_HIGH, 32'hFFFF_FFFF);
		rd("ep1 high", UWIR_OFS_EP1_HIGH, 32'h0000_0001);
		apb(1'b1, UWIR_OFS_EP1_HIGH, 32'h0000_0000);
		apb(1'b1, UWIR_OFS_EP1_LOW, 32'h0000_0080);
		apb(1'b1, UWIR_OFS_EP2_LOW, 32'h0000_0000);
		apb(1'b1, UWIR_OFS_EP2_HIGH, 32'h0000_0001);
		apb(1'b1, UWIR_OFS_AGG_CTRL, 32'h0000_0003);
		rd("ep1 low", UWIR_OFS_EP1_LOW, 32'h0000_0080);
		i_rx.send(1, 11'h040, 1'b0);
		i_rx.send(1, 11'h040, 1'b0);
		i_rx.idle();
		repeat (3) @(negedge sys_clk);
		chk("ep1 closes", 32'h0000_0001, n_close1);
		chk("ep1 length", 32'h0000_0080, {15'h0, len1});
		i_rx.send(1, 11'h020, 1'b1);
		i_rx.send(2, 11'h040, 1'b0);
		i_rx.send(2, 11'h00A, 1'b1);
		i_rx.idle();
		repeat (3) @(negedge sys_clk);
		chk("ep1 short closes", 32'h0000_0002, n_close1);
		chk("ep1 short length", 32'h0000_0020, {15'h0, len1});
		chk("ep2 closes", 32'h0000_0001, n_close2);
		chk("ep2 length", 32'h0000_004A, {15'h0, len2});
		// with aggregation off on ep1 every usb packet is its own dma packet
		apb(1'b1, UWIR_OFS_AGG_CTRL, 32'h0000_0002);
		rd("agg ctrl", UWIR_OFS_AGG_CTRL, 32'h0000_0002);
		i_rx.send(1, 11'h040, 1'b0);
		i_rx.idle();
		repeat (3) @(negedge sys_clk);
		chk("ep1 unmerged closes", 32'h0000_0003, n_close1);
		chk("ep1 unmerged length", 32'h0000_0040, {15'h0, len1});
		chk("ep2 untouched", 32'h0000_0001, n_close2);
		// unmapped address is refused with an error and zero data
		apb(1'b0, 8'h30, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, re});
		chk("unmapped data", 32'h0000_0000, rv);
		complete_run();
	end
	// cuts a hang short well beyond the expected run length
	initial
	begin
		#(40 * 3000);
		n_mismatch++;
		complete_run();
	end
endmodule
